// *** hdl/rst_seq_params.svh ***
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH

// Reset-cause codes for bits [7:6] of the program flag register
`define CAUSE_WATCHDOG      2'h0
`define CAUSE_RESERVED      2'h1
`define CAUSE_LOW_VOLTAGE   2'h2
`define CAUSE_EXTERNAL      2'h3
`define CAUSE_HI_BIT        7
`define CAUSE_LO_BIT        6

// Program start address after reset
`define START_ADDR          13'h0000

// Default widths in bits and counts in system clock cycles
`define WDT_WIDTH_DEFAULT   16
`define INIT_CYCLES_DEFAULT 8
`define WARMUP_CYCLES_DEF   4096
`define INIT_CNT_WIDTH      4
`define WARM_CNT_WIDTH      13

`endif

// *** hdl/rst_seq_pkg.sv ***
package rst_seq_pkg;

    typedef enum logic [4:0] {
        ST_HOLD   = 5'h01,
        ST_INIT   = 5'h02,
        ST_WARMUP = 5'h04,
        ST_RUN    = 5'h08,
        ST_WDT    = 5'h10
    } seq_state_t;

    // Outputs toward the core
    typedef struct packed {
        logic        core_reset_n;
        logic        reg_init;
        logic        normal_mode;
        logic [12:0] start_pc;
        logic [1:0]  cause;
    } core_ctl_t;

endpackage

// *** hdl/rst_watchdog.sv ***
`timescale 1ns/1ps

`include "rst_seq_params.svh"

// Watchdog counter, held cleared while run is low, with a software clear strobe
module rst_watchdog #(
    parameter int WIDTH = `WDT_WIDTH_DEFAULT
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    input  wire logic clear,
    output logic      overflow
);

    logic [WIDTH-1:0] count;
    logic [WIDTH:0]   next_count;

    assign next_count = {1'b0, count} + {{WIDTH{1'b0}}, 1'b1};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count    <= '0;
            overflow <= 1'b0;
        end else if (!run || clear) begin
            count    <= '0;
            overflow <= 1'b0;
        end else begin
            count    <= next_count[WIDTH-1:0];
            overflow <= next_count[WIDTH];
        end
    end

endmodule

// *** hdl/system_reset_sequencer.sv ***
`timescale 1ns/1ps

`include "rst_seq_params.svh"

// Behaviour
// - A watchdog overflow before software clears it starts a full reset.
// - After a watchdog reset the core restarts in normal operating mode.
// - Once the source clears, all system registers are loaded with defaults.
// - After initialisation the core waits for oscillator warm-up.
// - When the sequence ends, fetching begins at program address 0.
// - The watchdog counter is held at zero outside RUN; in RUN it increments every cycle until overflow or clear.
// - A low-voltage trip asserts system reset.
// - A low external reset input means reset; the device runs only when high.
// - The external reset input acts both at power-up and during running.
// - At power-up reset is held until the external input is released high.
// - Bits 7:6 of the flag register give the cause: 00 wdt, 10 lvd, 11 ext.
// - While any reset is active, execution halts with the program counter 0.
// - Writing one to the clear bit zeroes the counter; zero has no effect.
module system_reset_sequencer #(
    parameter int WDT_WIDTH     = `WDT_WIDTH_DEFAULT,
    parameter int INIT_CYCLES   = `INIT_CYCLES_DEFAULT,
    parameter int WARMUP_CYCLES = `WARMUP_CYCLES_DEF
) (
    input  wire logic                CLK_SYS,
    input  wire logic                RESETN,
    input  wire logic                EXT_RESETN,
    input  wire logic                LOW_VOLTAGE_TRIP,
    input  wire logic                OSC_STABLE,
    input  wire logic                WATCHDOG_CLEAR_BIT,
    output rst_seq_pkg::core_ctl_t   CORE_CTL,
    output logic                     WDT_OVERFLOW
);

    // Counter widths must hold INIT_CYCLES and WARMUP_CYCLES
    // Both counters restart at zero on every new sequence
    logic                        ext_sync1;
    logic                        ext_sync2;
    logic                        lvd_sync1;
    logic                        lvd_sync2;
    logic                        src_rst_n;
    rst_seq_pkg::seq_state_t     state;
    rst_seq_pkg::seq_state_t     next_state;
    logic [`INIT_CNT_WIDTH-1:0]  init_cnt;
    logic [`WARM_CNT_WIDTH-1:0]  warm_cnt;
    logic [1:0]                  cause;
    logic [1:0]                  next_cause;
    logic                        wdt_ovf;
    logic                        running;
    logic                        init_done;
    logic                        warm_done;
    logic                        in_init;
    logic                        in_warm;
    logic                        wdt_reset;
    logic                        lvd_active;
    logic                        ext_active;
    logic                        next_core_release;
    logic                        next_reg_init;
    logic                        next_wdt_pulse;
    logic                        next_normal_mode;
    logic [12:0]                 next_start_pc;
    logic [`INIT_CNT_WIDTH-1:0]  next_init_cnt;
    logic [`WARM_CNT_WIDTH-1:0]  next_warm_cnt;

    // Reset release is retimed; the assert path stays asynchronous
    // low input is reset
    assign src_rst_n = RESETN && EXT_RESETN && !LOW_VOLTAGE_TRIP;

    always_ff @(posedge CLK_SYS or negedge src_rst_n) begin
        if (!src_rst_n) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
        end else begin
            ext_sync1 <= 1'b1;
            ext_sync2 <= ext_sync1;
        end
    end

    // Trip level passes two flops; their reset value means tripped,
    // so a power-on reports the low-voltage cause unless EXT_RESETN is still low once they clear
    // trip resets the system
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            lvd_sync1 <= 1'b1;
            lvd_sync2 <= 1'b1;
        end else begin
            lvd_sync1 <= LOW_VOLTAGE_TRIP;
            lvd_sync2 <= lvd_sync1;
        end
    end

    // Phase decodes
    assign running   = (state == rst_seq_pkg::ST_RUN);
    assign in_init   = (state == rst_seq_pkg::ST_INIT);
    assign in_warm   = (state == rst_seq_pkg::ST_WARMUP);
    assign init_done = (init_cnt == `INIT_CNT_WIDTH'(INIT_CYCLES - 1));
    // Warm-up needs both the minimum count and a stable oscillator
    assign warm_done = (warm_cnt >= `WARM_CNT_WIDTH'(WARMUP_CYCLES - 1))
                       && OSC_STABLE;

    // Watchdog is held cleared outside RUN, so clears there are moot
    rst_watchdog #(
        .WIDTH    (WDT_WIDTH)
    ) u_watchdog (
        .clk      (CLK_SYS),
        .rst_n    (ext_sync2),
        .run      (running),
        .clear    (WATCHDOG_CLEAR_BIT),
        .overflow (wdt_ovf)
    );

    // A source must drop before the sequence may leave HOLD
    assign lvd_active = lvd_sync2;
    assign ext_active = !ext_sync2;
    assign wdt_reset  = wdt_ovf && running;

    // Sequence: HOLD, INIT, WARMUP, RUN; WDT is one cycle before INIT
    always_comb begin
        next_state = state;
        unique case (state)
            rst_seq_pkg::ST_HOLD: begin
                if (!lvd_active) begin
                    next_state = rst_seq_pkg::ST_INIT;
                end
            end
            rst_seq_pkg::ST_WDT: begin
                next_state = rst_seq_pkg::ST_INIT;
            end
            rst_seq_pkg::ST_INIT: begin
                if (init_done) begin
                    next_state = rst_seq_pkg::ST_WARMUP;
                end
            end
            rst_seq_pkg::ST_WARMUP: begin
                if (warm_done) begin
                    next_state = rst_seq_pkg::ST_RUN;
                end
            end
            rst_seq_pkg::ST_RUN: begin
                if (wdt_ovf) begin
                    next_state = rst_seq_pkg::ST_WDT;
                end
            end
        endcase
    end

    // cause encoding
    // Priority lvd over ext over watchdog; the reserved code never appears
    assign next_cause = lvd_active ? `CAUSE_LOW_VOLTAGE :
                        ext_active ? `CAUSE_EXTERNAL    :
                        wdt_reset  ? `CAUSE_WATCHDOG    :
                                     cause;

    // Counters restart whenever their phase is left
    assign next_init_cnt = in_init ? init_cnt + 1'b1 : '0;
    assign next_warm_cnt = (in_warm && !warm_done) ? warm_cnt + 1'b1 : '0;

    // start at address 0
    // Outputs follow the next state so the core sees them with it
    assign next_core_release = (next_state == rst_seq_pkg::ST_RUN);
    assign next_reg_init     = (next_state == rst_seq_pkg::ST_INIT);
    assign next_start_pc     = `START_ADDR;
    assign next_normal_mode  = 1'b1;
    assign next_wdt_pulse    = wdt_reset;

    // Any source but the watchdog drops the state straight back to HOLD
    always_ff @(posedge CLK_SYS or negedge ext_sync2) begin
        if (!ext_sync2) begin
            state <= rst_seq_pkg::ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Cause survives its own reset: cleared only by a new source
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            cause <= `CAUSE_LOW_VOLTAGE;
        end else begin
            cause <= next_cause;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ext_sync2) begin
        if (!ext_sync2) begin
            init_cnt <= '0;
            warm_cnt <= '0;
        end else begin
            init_cnt <= next_init_cnt;
            warm_cnt <= next_warm_cnt;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ext_sync2) begin
        if (!ext_sync2) begin
            CORE_CTL     <= '{core_reset_n: 1'b0, reg_init: 1'b0,
                              normal_mode: 1'b1, start_pc: `START_ADDR,
                              cause: `CAUSE_EXTERNAL};
            WDT_OVERFLOW <= 1'b0;
        end else begin
            CORE_CTL.core_reset_n <= next_core_release;
            CORE_CTL.reg_init     <= next_reg_init;
            CORE_CTL.normal_mode  <= next_normal_mode;
            CORE_CTL.start_pc     <= next_start_pc;
            CORE_CTL.cause        <= cause;
            WDT_OVERFLOW          <= next_wdt_pulse;
        end
    end

endmodule

// *** sim/reset_source_model.sv ***
`timescale 1ns/1ps
module reset_source_model (
    input  wire logic clk,
    input  wire logic ext_low,
    input  wire logic lvd_on,
    input  wire logic slow,
    output logic      ext_resetn,
    output logic      lvd_trip,
    output logic      osc_stable
);
    logic [5:0] warm = 6'h00;
    assign ext_resetn = !ext_low;
    assign lvd_trip   = lvd_on;
    // Oscillator restarts after an external or low-voltage source
    always @(posedge clk) begin
        if (ext_low || lvd_on)
            warm <= 6'h00;
        else if (warm != 6'h3F)
            warm <= warm + 6'h01;
    end
    assign osc_stable = warm > (slow ? 6'h28 : 6'h03);
endmodule

// *** sim/system_reset_sequencer_properties.sv ***
`timescale 1ns/1ps
module system_reset_sequencer_checker (
    input wire logic                  CLK_SYS,
    input wire logic                  RESETN,
    input wire logic                  EXT_RESETN,
    input wire logic                  LOW_VOLTAGE_TRIP,
    input wire logic                  OSC_STABLE,
    input wire logic                  WATCHDOG_CLEAR_BIT,
    input wire rst_seq_pkg::core_ctl_t CORE_CTL,
    input wire logic                  WDT_OVERFLOW
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    ext_hold_a: assert property (
        !EXT_RESETN |-> !CORE_CTL.core_reset_n)
        else $error("core runs with external reset low");
    lvd_hold_a: assert property (
        LOW_VOLTAGE_TRIP |-> !CORE_CTL.core_reset_n)
        else $error("core runs during low voltage");
    pc_zero_a: assert property (
        CORE_CTL.start_pc == 13'h0000)
        else $error("start address not zero");
    normal_mode_a: assert property (
        CORE_CTL.core_reset_n |-> CORE_CTL.normal_mode)
        else $error("core runs outside normal mode");
    osc_gate_a: assert property (
        $rose(CORE_CTL.core_reset_n) |-> $past(OSC_STABLE))
        else $error("core released before oscillator stable");
    warm_after_a: assert property (
        $fell(CORE_CTL.reg_init) |-> !CORE_CTL.core_reset_n [*4])
        else $error("warm-up shorter than four cycles");
    init_len_a: assert property (
        $rose(CORE_CTL.reg_init) |-> CORE_CTL.reg_init [*4])
        else $error("register load shorter than four cycles");
    wdt_cause_a: assert property (
        WDT_OVERFLOW |=> !CORE_CTL.core_reset_n
            && CORE_CTL.cause == 2'h0 && !WDT_OVERFLOW)
        else $error("watchdog overflow without reset");
    wdt_clear_a: assert property (
        $past(WATCHDOG_CLEAR_BIT) && $past(WATCHDOG_CLEAR_BIT, 2)
            |-> !WDT_OVERFLOW)
        else $error("overflow while clear held");
endmodule
bind system_reset_sequencer system_reset_sequencer_checker u_chk (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .EXT_RESETN(EXT_RESETN),
    .LOW_VOLTAGE_TRIP(LOW_VOLTAGE_TRIP), .OSC_STABLE(OSC_STABLE),
    .WATCHDOG_CLEAR_BIT(WATCHDOG_CLEAR_BIT), .CORE_CTL(CORE_CTL),
    .WDT_OVERFLOW(WDT_OVERFLOW));

// *** sim/system_reset_sequencer_test.sv ***
`timescale 1ns/1ps
module system_reset_sequencer_test;
    logic clk, rst_n, ext_low, lvd_on, slow, wclr, ext_n, low_voltage_detector, osc, ovf;
    rst_seq_pkg::core_ctl_t ctl;
    int n_fail = 0;
    int n_checks = 0;
    always #12.5 clk = !clk;
    reset_source_model SRC (.clk(clk), .ext_low(ext_low), .lvd_on(lvd_on),
        .slow(slow), .ext_resetn(ext_n), .lvd_trip(low_voltage_detector), .osc_stable(osc));
    system_reset_sequencer #(.WDT_WIDTH(6), .INIT_CYCLES(4),
        .WARMUP_CYCLES(4)) DUT (.CLK_SYS(clk), .RESETN(rst_n),
        .EXT_RESETN(ext_n), .LOW_VOLTAGE_TRIP(low_voltage_detector), .OSC_STABLE(osc),
        .WATCHDOG_CLEAR_BIT(wclr), .CORE_CTL(ctl), .WDT_OVERFLOW(ovf));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string s, logic [12:0] seen, logic [12:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic wait_run(output int n);
        n = 0;
        while (ctl.core_reset_n !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        if (n == 400) begin
            n_fail++;
            end_of_test();
        end
    endtask
    task automatic t_source(bit use_ext, logic [1:0] cause);
        int n;
        if (use_ext) ext_low = 1; else lvd_on = 1;
        #1;
        chk("async hold", ctl.core_reset_n, 1'b0);
        cyc(10);
        chk("held pc", ctl.start_pc, 13'h0000);
        ext_low = 0;
        lvd_on = 0;
        wait_run(n);
        chk("min delay", n >= 10, 1'b1);
        chk("cause", ctl.cause, cause);
        $display("source test done");
    endtask
    task automatic t_wdt();
        int n;
        wclr = 1;
        cyc(100);
        chk("cleared", ovf, 1'b0);
        wclr = 0;
        n = 0;
        while (ovf !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk("wdt period", n >= 62 && n <= 66, 1'b1);
        wait_run(n);
        chk("wdt cause", ctl.cause, 2'h0);
        chk("normal mode", ctl.normal_mode, 1'b1);
        $display("watchdog test done");
    endtask
    initial begin
        int n;
        clk = 0; rst_n = 0; ext_low = 0; lvd_on = 0; slow = 0; wclr = 0;
        cyc(20);
        rst_n = 1;
        wait_run(n);
        chk("boot pc", ctl.start_pc, 13'h0000);
        chk("boot cause", ctl.cause, 2'h2);
        chk("init done", ctl.reg_init, 1'b0);
        $display("boot test done");
        slow = 1;
        t_source(1, 2'h3);
        slow = 0;
        t_source(0, 2'h2);
        t_wdt();
        end_of_test();
    end
endmodule
